// ---- hdl/spm_pkg.sv ----
// Package with constants and types for the sync pin mode logic
package spm_pkg;

  // Pin function field codes
  localparam logic [3:0] CODE_SAMP_OUT_EXTCLK = 4'h5;
  localparam logic [3:0] CODE_SLAVE_EXPO = 4'h6;
  localparam logic [3:0] CODE_MASTER_EXPO = 4'h7;
  localparam logic [3:0] CODE_MASTER_EXPO_EXTCLK = 4'h8;

  // Exposure slot states that steer the external emitter multiplexer
  localparam logic [3:0] SLOT_FOURTH_EMITTER = 4'hA;
  localparam logic [3:0] SLOT_FIFTH_EMITTER = 4'hB;
  localparam logic [3:0] SLOT_SIXTH_EMITTER = 4'hC;

  // Sequence geometry
  localparam int SLOT_COUNT = 6;
  localparam int SLOT_W = 4;

  // Reset values of pin drivers
  localparam logic RST_PIN_LEVEL = 1'b0;
  localparam logic RST_PIN_OE = 1'b0;

  // Master sample pulse width on the sync pin
  localparam int CORE_CLK_HZ = 50_000_000;
  localparam int SAMPLE_PULSE_NS = 1000;
  localparam int SAMPLE_PULSE_CYC =
      (SAMPLE_PULSE_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_CNT_W = 8;

  // Decoded pin behaviour
  typedef enum logic [2:0] {
    SPM_MODE_OFF,
    SPM_MODE_SAMP_OUT_EXTCLK,
    SPM_MODE_SLAVE_EXPO,
    SPM_MODE_MASTER_EXPO,
    SPM_MODE_MASTER_EXPO_EXTCLK
  } spm_mode_t;

  // Programmed exposure sequence
  typedef struct packed {
    logic [SLOT_COUNT-1:0][SLOT_W-1:0] slot;
  } spm_seq_t;

  // Present exposure from the sequencer
  typedef struct packed {
    logic active;
    logic [SLOT_W-1:0] slot;
  } spm_expo_t;

  // One tristate pin driver
  typedef struct packed {
    logic level;
    logic oe;
  } spm_pin_t;

  // Internal timing events
  typedef struct packed {
    logic sample_tick;
    logic expo_tick;
    logic sample_start;
  } spm_timing_t;

endpackage

// ---- hdl/spm_edge_sync.sv ----
// Two-stage synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module spm_edge_sync (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges from the settled stages only
  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;

endmodule // spm_edge_sync

// ---- hdl/spm_sync_pin_mode.sv ----
// Function selection logic for the sync and aux pins in the sync modes
//
// Summary of operation
// RQ1: Decode four-bit pin function; 0101, 0110, 0111, 1000 pick the four behaviours.
// RQ2: Code 0101 drives sync pin as master sample output pulses.
// RQ3: Code 0101 takes aux pin as slow clock; exposure timing follows it.
// RQ4: Code 0110 is slave; sync pin trigger paces both samples and exposures.
// RQ5: In code 0110 the outside party drives the trigger onto sync pin.
// RQ6: Codes 0110/0111 drive aux pin as mux select only if slots A-C used.
// RQ7: Two-mux arrangement: select high during fourth to sixth emitter, else low.
// RQ8: Alternative 0110 reading: select low during fourth to sixth emitter, else high.
// RQ9: Without slots A-C in select modes, aux pin stays tristate.
// RQ10: Code 0111 drives sync pin as master exposure output.
// RQ11: Code 0111 takes sample and exposure timing from internal oscillator.
// RQ12: Code 1000 drives exposure output; aux clock paces samples and exposures.
// RQ13: Trigger and external clock are synchronised and edge-detected before use.
`timescale 1ns/1ps
module spm_sync_pin_mode (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] pin_mode_i,
  input wire logic mux_low_on_high_emitters_i,
  input wire spm_pkg::spm_seq_t exposure_slot_select_i,
  input wire spm_pkg::spm_expo_t expo_now_i,
  input wire spm_pkg::spm_timing_t int_timing_i,
  input wire logic sync_pin_i,
  input wire logic aux_pin_i,
  output logic sync_pin_o,
  output logic sync_pin_oe_o,
  output logic aux_pin_o,
  output logic aux_pin_oe_o,
  output spm_pkg::spm_timing_t timing_o,
  output logic expo_trigger_o
);

  // Map the pin function field to a behaviour
  function automatic spm_pkg::spm_mode_t decode_mode(input logic [3:0] code);
    spm_pkg::spm_mode_t m;
    m = spm_pkg::SPM_MODE_OFF;
    case (code)
      spm_pkg::CODE_SAMP_OUT_EXTCLK: m = spm_pkg::SPM_MODE_SAMP_OUT_EXTCLK;
      spm_pkg::CODE_SLAVE_EXPO: m = spm_pkg::SPM_MODE_SLAVE_EXPO;
      spm_pkg::CODE_MASTER_EXPO: m = spm_pkg::SPM_MODE_MASTER_EXPO;
      spm_pkg::CODE_MASTER_EXPO_EXTCLK: m = spm_pkg::SPM_MODE_MASTER_EXPO_EXTCLK;
      default: m = spm_pkg::SPM_MODE_OFF;
    endcase
    return m;
  endfunction

  // True for a slot state that routes through the external mux
  function automatic logic is_mux_slot(input logic [spm_pkg::SLOT_W-1:0] s);
    return (s == spm_pkg::SLOT_FOURTH_EMITTER) ||
           (s == spm_pkg::SLOT_FIFTH_EMITTER) ||
           (s == spm_pkg::SLOT_SIXTH_EMITTER);
  endfunction

  // Pin samplers; the aux clock is slow so edges are easy to see
  // Aux rising edges closer than two core cycles apart would merge into one
  logic trig_rise;
  logic clk_rise;

  spm_edge_sync u_trig_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(sync_pin_i),
    .level_o(),
    .rise_o(trig_rise),
    .fall_o()
  ); // RQ13

  spm_edge_sync u_clk_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(aux_pin_i),
    .level_o(),
    .rise_o(clk_rise),
    .fall_o()
  ); // RQ13

  // Mode decode
  // Unused codes decode to off: both pins released, internal timing
  spm_pkg::spm_mode_t mode;
  logic mode_samp_out;
  logic mode_slave;
  logic mode_master_int;
  logic mode_master_ext;
  logic aux_is_clock;
  logic aux_is_select;

  assign mode = decode_mode(pin_mode_i); // RQ1
  assign mode_samp_out = (mode == spm_pkg::SPM_MODE_SAMP_OUT_EXTCLK);
  assign mode_slave = (mode == spm_pkg::SPM_MODE_SLAVE_EXPO);
  assign mode_master_int = (mode == spm_pkg::SPM_MODE_MASTER_EXPO);
  assign mode_master_ext = (mode == spm_pkg::SPM_MODE_MASTER_EXPO_EXTCLK);
  assign aux_is_clock = mode_samp_out | mode_master_ext; // RQ3 RQ12
  assign aux_is_select = mode_slave | mode_master_int; // RQ6

  // Does the programmed sequence use any of the mux slots
  logic [spm_pkg::SLOT_COUNT-1:0] slot_hit;
  logic seq_uses_mux;

  for (genvar g = 0; g < spm_pkg::SLOT_COUNT; g++) begin : g_slot
    assign slot_hit[g] = is_mux_slot(exposure_slot_select_i.slot[g]);
  end
  assign seq_uses_mux = |slot_hit; // RQ6 RQ9

  // Select polarity: 0111 always high-active; 0110 may use the inverted reading.
  // The two descriptions of 0110 disagree, and the level that picks the upper
  // emitters depends on how the external mux is wired, so the system chooses.
  logic high_emitter_now;
  logic select_inverted;
  logic select_level;

  assign high_emitter_now = expo_now_i.active & is_mux_slot(expo_now_i.slot);
  assign select_inverted = mode_slave & mux_low_on_high_emitters_i; // RQ8
  assign select_level = high_emitter_now ^ select_inverted; // RQ7 RQ8

  // Timing origins: aux clock, sync pin trigger, or the internal oscillator
  logic use_ext_sample;
  logic use_ext_expo;
  logic use_trigger;
  logic trig_event;

  assign use_ext_sample = mode_master_ext; // RQ12
  assign use_ext_expo = aux_is_clock; // RQ3 RQ12
  assign use_trigger = mode_slave; // RQ4
  assign trig_event = use_trigger & trig_rise; // RQ4 RQ13

  // Timing source selection
  logic sample_tick_d;
  logic expo_tick_d;
  logic sample_start_d;

  // Sample clock: aux clock in 1000, none in slave, internal otherwise
  assign sample_tick_d = use_ext_sample ? clk_rise :
                         use_trigger ? 1'b0 :
                         int_timing_i.sample_tick; // RQ11 RQ12
  // Exposure clock: aux clock in 0101 and 1000, none in slave
  assign expo_tick_d = use_ext_expo ? clk_rise :
                       use_trigger ? 1'b0 :
                       int_timing_i.expo_tick; // RQ3 RQ11 RQ12
  // Sample start follows the external trigger in slave mode
  assign sample_start_d = use_trigger ? trig_event :
                          int_timing_i.sample_start; // RQ4 RQ5

  // Master sample pulse stretch, restarted by each internal sample start
  logic [spm_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;
  logic [spm_pkg::PULSE_CNT_W-1:0] pulse_cnt_d;
  localparam logic [spm_pkg::PULSE_CNT_W-1:0] PULSE_LOAD =
      spm_pkg::PULSE_CNT_W'(spm_pkg::SAMPLE_PULSE_CYC);

  logic pulse_load;
  logic pulse_live;

  // A new start reloads the full width; otherwise count down to idle
  assign pulse_load = mode_samp_out & int_timing_i.sample_start; // RQ2
  assign pulse_cnt_d = pulse_load ? PULSE_LOAD :
                       (pulse_cnt_q != '0) ? pulse_cnt_q - 1'b1 :
                       pulse_cnt_q; // RQ2
  assign pulse_live = (pulse_cnt_d != '0);

  // Pin drive selection
  spm_pkg::spm_pin_t sync_d;
  spm_pkg::spm_pin_t aux_d;

  // Sync pin roles; the exposure output carries the level, not an edge
  logic sync_is_sample_out;
  logic sync_is_expo_out;

  assign sync_is_sample_out = mode_samp_out; // RQ2
  assign sync_is_expo_out = mode_master_int | mode_master_ext; // RQ10 RQ12

  // Sync pin: sample pulse in 0101, exposure level in 0111/1000, input otherwise
  assign sync_d.oe = sync_is_sample_out | sync_is_expo_out; // RQ2 RQ10 RQ12
  assign sync_d.level = sync_is_sample_out ? pulse_live :
                        sync_is_expo_out ? expo_now_i.active :
                        spm_pkg::RST_PIN_LEVEL; // RQ2 RQ10

  // Aux pin: select only when the sequence needs it, tristate otherwise
  assign aux_d.oe = aux_is_select & seq_uses_mux; // RQ6 RQ9
  assign aux_d.level = aux_d.oe ? select_level : spm_pkg::RST_PIN_LEVEL; // RQ7

  // Pin and pulse registers; pins released until first decode after reset
  // Reset releases both pins so a neighbour on the line is never fought
  spm_pkg::spm_pin_t sync_q;
  spm_pkg::spm_pin_t aux_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pulse_cnt_q <= '0;
      sync_q <= {spm_pkg::RST_PIN_LEVEL, spm_pkg::RST_PIN_OE};
      aux_q <= {spm_pkg::RST_PIN_LEVEL, spm_pkg::RST_PIN_OE};
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
      sync_q <= sync_d;
      aux_q <= aux_d;
    end
  end

  // Timing event registers; edge events are one-cycle pulses, internal ticks keep the width they are driven with
  // A mode change reaches these outputs one cycle later
  spm_pkg::spm_timing_t timing_q;
  logic expo_trig_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      timing_q <= '0;
      expo_trig_q <= 1'b0;
    end else begin
      timing_q <= {sample_tick_d, expo_tick_d, sample_start_d};
      expo_trig_q <= trig_event; // RQ4
    end
  end

  // Outputs all from flip-flops
  assign sync_pin_o = sync_q.level;
  assign sync_pin_oe_o = sync_q.oe;
  assign aux_pin_o = aux_q.level;
  assign aux_pin_oe_o = aux_q.oe;
  assign timing_o = timing_q;
  assign expo_trigger_o = expo_trig_q;

endmodule // spm_sync_pin_mode

// ---- test/spm_sync_pin_mode_properties.sv ----
// Port checker for the sync pin mode logic
`timescale 1ns/1ps
module spm_sync_pin_mode_properties (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] pin_mode_i,
  input wire spm_pkg::spm_seq_t exposure_slot_select_i,
  input wire spm_pkg::spm_expo_t expo_now_i,
  input wire spm_pkg::spm_timing_t int_timing_i,
  input wire logic sync_pin_i,
  input wire logic sync_pin_o,
  input wire logic sync_pin_oe_o,
  input wire logic aux_pin_o,
  input wire logic aux_pin_oe_o,
  input wire spm_pkg::spm_timing_t timing_o,
  input wire logic expo_trigger_o
);
  // Single domain; $past guards skip the edge right after reset
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_trig_lat: assert property (
    $rose(sync_pin_i) && pin_mode_i == 4'h6 |-> ##[3:4] expo_trigger_o)
    else $error("slave trigger late");
  chk_trig_once: assert property (expo_trigger_o |=> !expo_trigger_o)
    else $error("trigger wider than one cycle");
  chk_trig_start: assert property (
    expo_trigger_o |-> timing_o.sample_start && pin_mode_i == 4'h6)
    else $error("trigger without sample start");
  chk_slave_ticks: assert property (
    pin_mode_i == 4'h6 && $past(pin_mode_i) == 4'h6
    |-> !timing_o.sample_tick && !timing_o.expo_tick)
    else $error("internal tick in slave mode");
  chk_expo_out: assert property (
    $past(rst_n_i) && $past(pin_mode_i) inside {4'h7, 4'h8}
    |-> sync_pin_oe_o && sync_pin_o == $past(expo_now_i.active))
    else $error("exposure output wrong");
  chk_aux_input: assert property (
    $past(rst_n_i) && $past(pin_mode_i) inside {4'h5, 4'h8} |-> !aux_pin_oe_o)
    else $error("aux pin driven in clock mode");
  chk_samp_rise: assert property (
    $past(rst_n_i) && $past(pin_mode_i) == 4'h5 && $past(int_timing_i.sample_start)
    |-> sync_pin_oe_o && sync_pin_o)
    else $error("sample pulse missing");
  chk_pins_free: assert property (
    $past(rst_n_i) && !($past(pin_mode_i) inside {[4'h5:4'h8]})
    |-> !sync_pin_oe_o && !aux_pin_oe_o)
    else $error("pin driven in unused code");
  chk_aux_tristate: assert property (
    $past(rst_n_i) && $past(exposure_slot_select_i) == '0 |-> !aux_pin_oe_o)
    else $error("aux pin driven without mux slots");
  chk_sel_level: assert property (
    $past(rst_n_i) && $past(pin_mode_i) == 4'h7 && aux_pin_oe_o
    |-> aux_pin_o == ($past(expo_now_i.active) &&
                      ($past(expo_now_i.slot) inside {4'hA, 4'hB, 4'hC})))
    else $error("mux select level wrong");
endmodule // spm_sync_pin_mode_properties
bind spm_sync_pin_mode spm_sync_pin_mode_properties u_props (
  .core_clk_i, .rst_n_i, .pin_mode_i, .exposure_slot_select_i, .expo_now_i, .int_timing_i,
  .sync_pin_i, .sync_pin_o, .sync_pin_oe_o, .aux_pin_o, .aux_pin_oe_o, .timing_o,
  .expo_trigger_o
);

// ---- test/spm_far_side.sv ----
// Far-side model: trigger source and slow clock source
`timescale 1ns/1ps
module spm_far_side (
  input wire logic clk_run_i,
  input wire logic trig_i,
  output logic aux_clk_o,
  output logic trig_o
);
  // Slow clock, 160 ns period, held still outside frames; phase unrelated to core
  initial begin
    aux_clk_o = 1'b0;
    #7;
    forever #80 aux_clk_o = clk_run_i ? ~aux_clk_o : aux_clk_o;
  end
  assign trig_o = trig_i;
endmodule // spm_far_side

// ---- test/tb_sync_pin_mode_logic.sv ----
// Self-checking bench for the sync pin mode logic
`timescale 1ns/1ps
module tb_sync_pin_mode_logic;
  logic core_clk_i, rst_n_i, mux_lo, run, trig, aux_far, sync_far, sync_w, aux_w;
  logic sync_o, sync_oe, aux_o, aux_oe, etrig;
  logic [3:0] mode;
  spm_pkg::spm_seq_t seq;
  spm_pkg::spm_expo_t expo;
  spm_pkg::spm_timing_t itim, tim;
  int errors, n_tests, k, e, s;
  // Pin levels; a released aux line is pulled up
  assign sync_w = sync_oe ? sync_o : sync_far;
  assign aux_w = aux_oe ? aux_o : (run ? aux_far : 1'b1);
  spm_sync_pin_mode dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .pin_mode_i(mode),
    .mux_low_on_high_emitters_i(mux_lo), .exposure_slot_select_i(seq), .expo_now_i(expo),
    .int_timing_i(itim), .sync_pin_i(sync_w), .aux_pin_i(aux_w), .sync_pin_o(sync_o),
    .sync_pin_oe_o(sync_oe), .aux_pin_o(aux_o), .aux_pin_oe_o(aux_oe), .timing_o(tim),
    .expo_trigger_o(etrig));
  spm_far_side far (.clk_run_i(run), .trig_i(trig), .aux_clk_o(aux_far), .trig_o(sync_far));
  // Core clock, 20 ns
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      $display("unexpected %s expected %h seen %h", nm, ex, got);
      errors++;
    end
  endtask
  // Counts timing ticks over n cycles
  task automatic count(input int n);
    e = 0;
    s = 0;
    repeat (n) begin
      tick(1);
      #1;
      e += int'(tim.expo_tick === 1'b1);
      s += int'(tim.sample_tick === 1'b1);
    end
  endtask
  // Slave: trigger paces samples, internal ticks ignored, aux mux select both polarities
  task automatic t_slave();
    mode <= 4'h6;
    itim <= 3'b110;
    tick(4);
    trig <= 1'b1;
    k = 0;
    repeat (6) begin
      tick(1);
      #1;
      k++;
      if (etrig === 1'b1 && tim.sample_start === 1'b1) e = k;
    end
    chk("trig cycle", 8'h1, 8'(e == 3 || e == 4));
    chk("pins oe", 8'h0, {sync_oe, aux_oe});
    trig <= 1'b0;
    seq.slot[2] <= spm_pkg::SLOT_SIXTH_EMITTER;
    expo <= {1'b1, spm_pkg::SLOT_FOURTH_EMITTER};
    tick(2);
    #1;
    chk("aux high", 8'h3, {aux_oe, aux_o});
    mux_lo <= 1'b1;
    tick(2);
    #1;
    chk("aux low", 8'h2, {aux_oe, aux_o});
    expo <= {1'b1, 4'h1};
    tick(2);
    #1;
    chk("aux other", 8'h3, {aux_oe, aux_o});
    $display("slave test done");
  endtask
  // Master exposure output from internal timing; mux select ignores the invert input
  task automatic t_master();
    tick(1);
    mode <= 4'h7;
    seq <= '0;
    itim <= 3'b111;
    expo <= {1'b1, 4'hA};
    tick(1);
    #1;
    chk("expo out", 8'h3, {sync_oe, sync_o});
    chk("aux none", 8'h0, aux_oe);
    chk("int timing", 8'h7, tim);
    itim <= '0;
    seq.slot[5] <= spm_pkg::SLOT_FIFTH_EMITTER;
    expo <= {1'b1, 4'h3};
    tick(2);
    #1;
    chk("aux off slot", 8'h2, {aux_oe, aux_o});
    expo <= {1'b1, spm_pkg::SLOT_SIXTH_EMITTER};
    tick(1);
    #1;
    chk("aux c slot", 8'h3, {aux_oe, aux_o});
    expo <= '0;
    tick(1);
    #1;
    chk("expo end", 8'h2, {sync_oe, sync_o});
    $display("master test done");
  endtask
  // External slow clock paces both ticks in code 8 and exposure ticks in code 5; sample pulse width in code 5
  task automatic t_ext();
    tick(1);
    mode <= 4'h8;
    itim <= 3'b110;
    run <= 1'b1;
    count(80);
    chk("ext ticks", 8'h1, 8'(e >= 9 && e <= 11 && s == e));
    chk("aux in", 8'h0, aux_oe);
    mode <= 4'h5;
    itim <= 3'b001;
    tick(1);
    itim <= '0;
    k = 0;
    repeat (60) begin
      #1;
      k += int'(sync_o === 1'b1 && sync_oe === 1'b1);
      tick(1);
    end
    chk("pulse", 8'(spm_pkg::SAMPLE_PULSE_CYC), 8'(k));
    itim <= 3'b110;
    count(80);
    chk("aux expo", 8'h1, 8'(e >= 9 && e <= 11 && s == 80));
    run <= 1'b0;
    $display("clock input test done");
  endtask
  // Reset in mid-run releases driven pins; decode resumes on the first edge after it
  task automatic t_rst();
    tick(1);
    mode <= 4'h7;
    expo <= {1'b1, spm_pkg::SLOT_FOURTH_EMITTER};
    tick(2);
    rst_n_i <= 1'b0;
    tick(2);
    #1;
    chk("reset pins", 8'h0, {sync_oe, sync_o, aux_oe, aux_o, tim, etrig});
    tick(1);
    rst_n_i <= 1'b1;
    tick(1);
    #1;
    chk("after reset", 8'h3, {sync_oe, sync_o});
    $display("reset test done");
  endtask
  // Unused codes release both pins
  task automatic t_off();
    logic [3:0] c [4] = '{4'h0, 4'h4, 4'h9, 4'hF};
    for (int i = 0; i < 4; i++) begin
      tick(1);
      mode <= c[i];
      expo <= {1'b1, 4'hA};
      tick(2);
      #1;
      chk("released", 8'h0, {sync_oe, aux_oe});
    end
    $display("release test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n_i, mux_lo, run, trig, mode, seq, expo, itim} = '0;
    errors = 0;
    n_tests = 0;
    tick(4);
    rst_n_i <= 1'b1;
    tick(1);
    #1;
    chk("reset", 8'h0, {sync_oe, aux_oe, etrig});
    t_slave();
    t_master();
    t_rst();
    t_ext();
    t_off();
    results();
  end
  // Watchdog, several times the expected run
  initial begin
    #50000;
    errors++;
    results();
  end
endmodule // tb_sync_pin_mode_logic
